//--- core/swd_port.sv
// Top of the single-wire debug serial port, target side.
// Assumes memory bus handshake and halt/run control come from the core.
`timescale 1ns/1ps
module swd_port
    import swd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_bus_tick,
    input wire logic i_alt_tick,
    input wire logic i_debug_pin,
    output logic o_debug_pin,
    output logic o_debug_pin_oe,
    input wire logic i_halted,
    output logic o_halt_req,
    output logic o_go_req,
    output logic o_mem_req,
    output logic o_mem_write,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    output logic o_ack_enabled,
    output logic [15:0] o_breakpoint_match,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [7:0] o_rd_data
);
    logic pin_meta;
    logic pin_sync;
    logic dbg_tick;
    logic [7:0] debug_status_control;
    logic [15:0] breakpoint_match;
    swd_state_t state;
    logic [7:0] cmd;
    logic [15:0] shreg;
    logic [4:0] nbits;
    logic [15:0] addr_field;
    logic [15:0] last_addr;
    logic [7:0] rdata;
    logic tx_mode;
    logic tx_bit;
    logic bit_done;
    logic rx_bit;
    logic timeout;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [4:0] delay_cnt;
    logic is_write_cmd;
    logic ack_flag;

    // Two-stage synchroniser; first stage read only by the second
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= i_debug_pin;
            pin_sync <= pin_meta;
        end
    end

    // Select bit set: bus clock; cleared: alternate
    assign dbg_tick = debug_status_control[SWD_SC_CLKSEL_BIT] ? i_bus_tick : i_alt_tick;

    swd_bit_engine u_bit (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_dbg_tick(dbg_tick),
        .i_pin_sync(pin_sync),
        .i_tx_mode(tx_mode),
        .i_tx_bit(tx_bit),
        .o_bit_done(bit_done),
        .o_rx_bit(rx_bit),
        .o_timeout(timeout),
        .o_probe_done(),
        .o_pin_out(o_debug_pin),
        .o_pin_oe(o_debug_pin_oe)
    );

    // Memory read bytes (not status or match bytes) also flow through a FIFO to a trace consumer
    swd_fifo #(
        .WIDTH(SWD_FIFO_WIDTH),
        .DEPTH(SWD_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(rdata),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data)
    );

    assign tx_mode = (state == SWD_ST_STAT) || (state == SWD_ST_RDATA);
    assign tx_bit = shreg[4'(nbits - 5'h01)];
    assign is_write_cmd = (cmd == SWD_CMD_BYTE_STORE) || (cmd == SWD_CMD_BYTE_STORE_WS);
    assign o_ack_enabled = ack_flag;
    assign o_breakpoint_match = breakpoint_match;
    assign o_mem_addr = addr_field;

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state <= SWD_ST_IDLE;
            cmd <= '0;
            shreg <= '0;
            nbits <= '0;
            addr_field <= '0;
            last_addr <= '0;
            rdata <= '0;
            delay_cnt <= '0;
            debug_status_control <= SWD_SC_RESET;
            breakpoint_match <= SWD_MATCH_RESET;
            ack_flag <= 1'b0;
            o_halt_req <= 1'b0;
            o_go_req <= 1'b0;
            o_mem_req <= 1'b0;
            o_mem_write <= 1'b0;
            o_mem_wdata <= '0;
            fifo_in_valid <= 1'b0;
        end else begin
            o_halt_req <= 1'b0;
            o_go_req <= 1'b0;
            if (fifo_in_valid && fifo_in_ready) begin
                fifo_in_valid <= 1'b0;
            end
            if (timeout && state != SWD_ST_MEMWAIT) begin
                state <= SWD_ST_CODE;
                nbits <= 5'h08;
                shreg <= '0;
            end else begin
                case (state)
                    SWD_ST_IDLE: begin
                        state <= SWD_ST_CODE;
                        nbits <= 5'h08;
                        shreg <= '0;
                    end
                    SWD_ST_CODE: begin
                        if (bit_done) begin
                            shreg <= {shreg[14:0], rx_bit};
                            nbits <= nbits - 5'h01;
                            if (nbits == 5'h01) begin
                                cmd <= {shreg[6:0], rx_bit};
                                state <= SWD_ST_DONE;
                            end
                        end
                    end
                    SWD_ST_DONE: begin
                        // Decode the code just captured
                        state <= SWD_ST_DELAY;
                        delay_cnt <= '0;
                        nbits <= '0;
                        case (cmd)
                            SWD_CMD_BYTE_FETCH, SWD_CMD_BYTE_FETCH_WS, SWD_CMD_BYTE_STORE,
                            SWD_CMD_BYTE_STORE_WS: begin
                                state <= SWD_ST_ADDR;
                                nbits <= 5'h10;
                            end
                            SWD_CMD_STORE_CONTROL: begin
                                state <= SWD_ST_WDATA;
                                nbits <= 5'h08;
                            end
                            SWD_CMD_MATCH_STORE: begin
                                state <= SWD_ST_WDATA;
                                nbits <= 5'h10;
                            end
                            SWD_CMD_FETCH_STATUS, SWD_CMD_FETCH_LAST: begin
                                state <= SWD_ST_STAT;
                                shreg <= {8'h00, debug_status_control};
                                nbits <= 5'h08;
                            end
                            SWD_CMD_MATCH_FETCH: begin
                                state <= SWD_ST_RDATA;
                                shreg <= breakpoint_match;
                                nbits <= 5'h10;
                            end
                            SWD_CMD_ACK_ENABLE: begin
                                ack_flag <= 1'b1;
                            end
                            SWD_CMD_ENTER_BGND: begin
                                o_halt_req <= debug_status_control[SWD_SC_ENABLE_BIT];
                                state <= SWD_ST_IDLE;
                            end
                            SWD_CMD_GO: begin
                                if (!i_halted) begin
                                    state <= SWD_ST_IDLE;
                                end
                            end
                            default: begin
                                state <= SWD_ST_IDLE;
                            end
                        endcase
                    end
                    SWD_ST_ADDR, SWD_ST_WDATA: begin
                        if (bit_done) begin
                            shreg <= {shreg[14:0], rx_bit};
                            nbits <= nbits - 5'h01;
                            if (nbits == 5'h01) begin
                                if (state == SWD_ST_ADDR) begin
                                    addr_field <= {shreg[14:0], rx_bit};
                                    if (is_write_cmd) begin
                                        state <= SWD_ST_WDATA;
                                        nbits <= 5'h08;
                                    end else begin
                                        state <= SWD_ST_MEMWAIT;
                                        o_mem_req <= 1'b1;
                                        o_mem_write <= 1'b0;
                                    end
                                end else if (cmd == SWD_CMD_STORE_CONTROL) begin
                                    debug_status_control <= {shreg[6:0], rx_bit};
                                    state <= SWD_ST_IDLE;
                                end else if (cmd == SWD_CMD_MATCH_STORE) begin
                                    breakpoint_match <= {shreg[14:0], rx_bit};
                                    state <= SWD_ST_IDLE;
                                end else begin
                                    o_mem_wdata <= {shreg[6:0], rx_bit};
                                    o_mem_req <= 1'b1;
                                    o_mem_write <= 1'b1;
                                    state <= SWD_ST_MEMWAIT;
                                end
                            end
                        end
                    end
                    SWD_ST_MEMWAIT: begin
                        if (i_mem_ack) begin
                            o_mem_req <= 1'b0;
                            state <= SWD_ST_DELAY;
                            delay_cnt <= '0;
                            last_addr <= addr_field;
                            if (!o_mem_write) begin
                                rdata <= i_mem_rdata;
                            end
                        end
                    end
                    SWD_ST_DELAY: begin
                        if (dbg_tick) begin
                            delay_cnt <= delay_cnt + 5'h01;
                            if (delay_cnt == 5'(SWD_BIT_CYCLES - 1)) begin
                                state <= SWD_ST_IDLE;
                                if (cmd == SWD_CMD_GO) begin
                                    o_go_req <= 1'b1;
                                end
                                if (cmd == SWD_CMD_BYTE_FETCH) begin
                                    state <= SWD_ST_RDATA;
                                    shreg <= {8'h00, rdata};
                                    nbits <= 5'h08;
                                end
                                if (cmd == SWD_CMD_BYTE_FETCH_WS ||
                                    cmd == SWD_CMD_BYTE_STORE_WS) begin
                                    state <= SWD_ST_STAT;
                                    shreg <= {8'h00, debug_status_control};
                                    nbits <= 5'h08;
                                end
                            end
                        end
                    end
                    SWD_ST_STAT, SWD_ST_RDATA: begin
                        if (bit_done) begin
                            nbits <= nbits - 5'h01;
                            if (nbits == 5'h01) begin
                                state <= SWD_ST_IDLE;
                                if (state == SWD_ST_STAT && cmd != SWD_CMD_FETCH_STATUS &&
                                    cmd != SWD_CMD_BYTE_STORE_WS) begin
                                    state <= SWD_ST_RDATA;
                                    shreg <= {8'h00, rdata};
                                    nbits <= 5'h08;
                                    if (cmd == SWD_CMD_FETCH_LAST) begin
                                        addr_field <= last_addr;
                                    end
                                end
                                if (state == SWD_ST_RDATA && cmd != SWD_CMD_MATCH_FETCH) begin
                                    fifo_in_valid <= 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        state <= SWD_ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

//--- core/swd_pkg.sv
// Constants shared by the single-wire debug serial port.
// Assumes one 200 MHz system clock; debug clock arrives as enable pulses.
package swd_pkg;
    localparam int unsigned SWD_BIT_CYCLES = 16;
    localparam int unsigned SWD_TIMEOUT_CYCLES = 512;
    localparam int unsigned SWD_SAMPLE_AT = 10;
    localparam int unsigned SWD_ONE_PULSE_AT = 7;
    localparam int unsigned SWD_ZERO_LOW_CYCLES = 13;
    localparam int unsigned SWD_PROBE_DETECT = 128;
    localparam int unsigned SWD_PROBE_WAIT = 16;
    localparam int unsigned SWD_PROBE_LOW = 128;
    localparam int unsigned SWD_FIFO_DEPTH = 16;
    localparam int unsigned SWD_FIFO_WIDTH = 8;
    localparam logic [7:0] SWD_CMD_ACK_ENABLE = 8'hd5;
    localparam logic [7:0] SWD_CMD_ENTER_BGND = 8'h90;
    localparam logic [7:0] SWD_CMD_FETCH_STATUS = 8'he4;
    localparam logic [7:0] SWD_CMD_STORE_CONTROL = 8'hc4;
    localparam logic [7:0] SWD_CMD_BYTE_FETCH = 8'he0;
    localparam logic [7:0] SWD_CMD_BYTE_FETCH_WS = 8'he1;
    localparam logic [7:0] SWD_CMD_FETCH_LAST = 8'he8;
    localparam logic [7:0] SWD_CMD_BYTE_STORE = 8'hc0;
    localparam logic [7:0] SWD_CMD_BYTE_STORE_WS = 8'hc1;
    localparam logic [7:0] SWD_CMD_MATCH_FETCH = 8'he2;
    localparam logic [7:0] SWD_CMD_MATCH_STORE = 8'hc2;
    localparam logic [7:0] SWD_CMD_GO = 8'h08;
    // Bit positions inside the status/control byte
    localparam int unsigned SWD_SC_ENABLE_BIT = 7;
    localparam int unsigned SWD_SC_ACTIVE_BIT = 6;
    localparam int unsigned SWD_SC_CLKSEL_BIT = 2;
    localparam logic [7:0] SWD_SC_RESET = 8'h00;
    localparam logic [15:0] SWD_MATCH_RESET = 16'h0000;
    typedef enum logic [8:0] {
        SWD_ST_IDLE = 9'h001,
        SWD_ST_CODE = 9'h002,
        SWD_ST_ADDR = 9'h004,
        SWD_ST_WDATA = 9'h008,
        SWD_ST_DELAY = 9'h010,
        SWD_ST_STAT = 9'h020,
        SWD_ST_RDATA = 9'h040,
        SWD_ST_MEMWAIT = 9'h080,
        SWD_ST_DONE = 9'h100
    } swd_state_t;
endpackage

//--- core/swd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes writer and reader share one clock.
`timescale 1ns/1ps
module swd_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_in_ready = (count < (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr];

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- core/swd_bit_engine.sv
// Bit-level timing on the single debug wire.
// Assumes i_dbg_tick marks each debug clock cycle; pin already synchronised.
`timescale 1ns/1ps
module swd_bit_engine
    import swd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_dbg_tick,
    input wire logic i_pin_sync,
    input wire logic i_tx_mode,
    input wire logic i_tx_bit,
    output logic o_bit_done,
    output logic o_rx_bit,
    output logic o_timeout,
    output logic o_probe_done,
    output logic o_pin_out,
    output logic o_pin_oe
);
    logic pin_prev;
    logic busy;
    logic tx_latched;
    logic [4:0] bit_cnt;
    logic [9:0] idle_cnt;
    logic [7:0] low_cnt;
    logic [7:0] probe_cnt;
    logic [1:0] probe_ph;
    logic fall;

    assign fall = pin_prev && !i_pin_sync;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= i_pin_sync;
        end
    end

    // Bit timing counts from the synchronised edge, hence the lag
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            busy <= 1'b0;
            bit_cnt <= '0;
            tx_latched <= 1'b0;
            o_bit_done <= 1'b0;
            o_rx_bit <= 1'b0;
        end else begin
            o_bit_done <= 1'b0;
            if (fall && !busy && probe_ph == 2'h0) begin
                busy <= 1'b1;
                bit_cnt <= '0;
                tx_latched <= i_tx_mode && i_tx_bit;
            end else if (busy && i_dbg_tick) begin
                bit_cnt <= bit_cnt + 5'h01;
                if (!i_tx_mode && bit_cnt == 5'(SWD_SAMPLE_AT - 1)) begin
                    o_rx_bit <= i_pin_sync;
                end
                if (bit_cnt == 5'(SWD_BIT_CYCLES - 1)) begin
                    busy <= 1'b0;
                    o_bit_done <= 1'b1;
                end
            end
        end
    end

    // Pin drive: only in target-to-host bits and probe replies
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_pin_out <= 1'b1;
            o_pin_oe <= 1'b0;
        end else if (probe_ph == 2'h2) begin
            o_pin_out <= 1'b0;
            o_pin_oe <= 1'b1;
        end else if (probe_ph == 2'h3) begin
            o_pin_out <= 1'b1;
            o_pin_oe <= 1'b1;
        end else if (busy && i_tx_mode) begin
            if (tx_latched) begin
                o_pin_out <= 1'b1;
                o_pin_oe <= (bit_cnt == 5'(SWD_ONE_PULSE_AT));
            end else begin
                o_pin_out <= (bit_cnt == 5'(SWD_ZERO_LOW_CYCLES));
                o_pin_oe <= (bit_cnt <= 5'(SWD_ZERO_LOW_CYCLES));
            end
        end else begin
            o_pin_out <= 1'b1;
            o_pin_oe <= 1'b0;
        end
    end

    // Idle timeout between host edges
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            idle_cnt <= '0;
            o_timeout <= 1'b0;
        end else begin
            o_timeout <= 1'b0;
            if (fall) begin
                idle_cnt <= '0;
            end else if (i_dbg_tick && idle_cnt != 10'(SWD_TIMEOUT_CYCLES)) begin
                idle_cnt <= idle_cnt + 10'h001;
                if (idle_cnt == 10'(SWD_TIMEOUT_CYCLES - 1)) begin
                    o_timeout <= 1'b1;
                end
            end
        end
    end

    // Rate probe: long low detect, wait, 128-cycle low reply, one-cycle pulse
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            low_cnt <= '0;
            probe_cnt <= '0;
            probe_ph <= 2'h0;
            o_probe_done <= 1'b0;
        end else begin
            o_probe_done <= 1'b0;
            if (i_pin_sync || probe_ph != 2'h0) begin
                low_cnt <= '0;
            end else if (i_dbg_tick && low_cnt != 8'(SWD_PROBE_DETECT)) begin
                low_cnt <= low_cnt + 8'h01;
            end
            case (probe_ph)
                2'h0: begin
                    if (i_pin_sync && low_cnt == 8'(SWD_PROBE_DETECT)) begin
                        probe_ph <= 2'h1;
                        probe_cnt <= '0;
                    end
                end
                2'h1: begin
                    if (i_dbg_tick) begin
                        probe_cnt <= probe_cnt + 8'h01;
                        if (probe_cnt == 8'(SWD_PROBE_WAIT - 1)) begin
                            probe_ph <= 2'h2;
                            probe_cnt <= '0;
                        end
                    end
                end
                2'h2: begin
                    if (i_dbg_tick) begin
                        probe_cnt <= probe_cnt + 8'h01;
                        if (probe_cnt == 8'(SWD_PROBE_LOW - 1)) begin
                            probe_ph <= 2'h3;
                        end
                    end
                end
                default: begin
                    if (i_dbg_tick) begin
                        probe_ph <= 2'h0;
                        o_probe_done <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

//--- dv/swd_port_sva.sv
// Assertions on the debug port outputs.
// Assumes one debug clock count per mclk cycle.
`timescale 1ns/1ps
module swd_port_sva (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic o_debug_pin,
    input wire logic o_debug_pin_oe,
    input wire logic i_halted,
    input wire logic o_halt_req,
    input wire logic o_go_req,
    input wire logic o_mem_req,
    input wire logic [15:0] o_mem_addr,
    input wire logic i_mem_ack,
    input wire logic o_rd_valid,
    input wire logic i_rd_ready,
    input wire logic [7:0] o_rd_data
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    logic [7:0] lowrun;
    // Length of the current target-driven low stretch
    always_ff @(posedge i_mclk) begin
        if (i_reset) lowrun <= 8'h00;
        else lowrun <= (o_debug_pin_oe && !o_debug_pin) ? lowrun + 8'h01 : 8'h00;
    end
    sequence mem_wait_s; o_mem_req && !i_mem_ack; endsequence
    sequence speedup_s; o_debug_pin_oe && o_debug_pin; endsequence
    reset_idle_a: assert property ($fell(i_reset) |-> !o_debug_pin_oe && !o_mem_req)
        else $error("port not idle after reset");
    low_length_a: assert property (speedup_s |-> lowrun == 8'h00 || lowrun == 8'h0d || lowrun == 8'h80)
        else $error("driven low for a wrong count");
    speedup_once_a: assert property (speedup_s |=> !o_debug_pin_oe)
        else $error("speedup pulse too long");
    go_halted_a: assert property (o_go_req |-> $past(i_halted))
        else $error("resume while running");
    halt_pulse_a: assert property (o_halt_req |=> !o_halt_req)
        else $error("halt request not a pulse");
    mem_hold_a: assert property (mem_wait_s |=> o_mem_req && $stable(o_mem_addr))
        else $error("memory request dropped");
    mem_drop_a: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
        else $error("memory request after ack");
    fifo_hold_a: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
        else $error("fifo output changed while stalled");
endmodule
bind swd_port swd_port_sva chk_u (.i_mclk, .i_reset, .o_debug_pin, .o_debug_pin_oe, .i_halted,
    .o_halt_req, .o_go_req, .o_mem_req, .o_mem_addr, .i_mem_ack, .o_rd_valid, .i_rd_ready,
    .o_rd_data);

//--- dv/swd_host.sv
// Behavioural debug host on the single wire.
// Assumes a pull-up on the wire and one debug count per mclk.
`timescale 1ns/1ps
module swd_host (
    input wire logic i_mclk,
    input wire logic i_pin,
    output logic o_pull_low
);
    initial o_pull_low = 1'b0;
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            o_pull_low = 1'b1;
            wait_n(v[i] ? 4 : 16);
            o_pull_low = 1'b0;
            wait_n(v[i] ? 20 : 8);
        end
    endtask
    task automatic get(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            o_pull_low = 1'b1;
            wait_n(3);
            o_pull_low = 1'b0;
            wait_n(9);
            v[i] = i_pin;
            wait_n(12);
        end
    endtask
    task automatic probe(output int low);
        low = 0;
        o_pull_low = 1'b1;
        wait_n(140);
        o_pull_low = 1'b0;
        for (int i = 0; i < 400; i++) begin
            wait_n(1);
            low += (i_pin === 1'b0);
        end
    endtask
endmodule

//--- dv/swd_port_tb.sv
// Self-checking bench for the debug port with a host model.
// Assumes the selected debug clock ticks every mclk cycle.
`timescale 1ns/1ps
module swd_port_tb;
    logic i_mclk = 0, i_reset = 1, i_bus_tick = 0, i_halted = 0, i_mem_ack = 0, i_rd_ready = 0;
    logic [7:0] i_mem_rdata = 8'h00, o_rd_data, o_mem_wdata, b, d, wd, c;
    logic o_debug_pin, o_debug_pin_oe, o_halt_req, o_go_req, o_mem_req, o_mem_write;
    logic o_ack_enabled, o_rd_valid, host_low, wire_lvl, hold = 0, sel = 0, i_alt_tick = 1;
    logic [15:0] o_mem_addr, o_breakpoint_match, a, wa;
    int fails = 0, total_checks = 0, halts = 0, gos = 0, seed = 32'h91b1ab54, n;
    logic [7:0] q[$];
    // Released wire is pulled up
    assign wire_lvl = host_low ? 1'b0 : (o_debug_pin_oe ? o_debug_pin : 1'b1);
    initial forever #2.5 i_mclk = ~i_mclk;
    swd_port dut_u (.i_mclk, .i_reset, .i_bus_tick, .i_alt_tick, .i_debug_pin(wire_lvl),
        .o_debug_pin, .o_debug_pin_oe, .i_halted, .o_halt_req, .o_go_req, .o_mem_req,
        .o_mem_write, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata, .o_ack_enabled,
        .o_breakpoint_match, .o_rd_valid, .i_rd_ready, .o_rd_data);
    swd_host host_u (.i_mclk, .i_pin(wire_lvl), .o_pull_low(host_low));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge i_mclk) begin
        i_bus_tick <= sel | 1'($random(seed));
        i_alt_tick <= !sel;
        i_rd_ready <= !hold && 1'($random(seed));
        i_mem_ack <= o_mem_req && !i_mem_ack;
        i_mem_rdata <= o_mem_addr[7:0] ^ 8'h3c;
        if (o_mem_req) {wa, wd} <= {o_mem_addr, o_mem_wdata};
    end
    always @(posedge i_mclk) begin
        halts += (o_halt_req === 1'b1);
        gos += (o_go_req === 1'b1);
        if (o_rd_valid === 1'b1 && i_rd_ready) check("fifo", o_rd_data, q.pop_front());
    end
    initial begin
        repeat (40000) @(posedge i_mclk);
        fails++;
        final_report();
    end
    initial begin
        repeat (2) @(negedge i_mclk);
        i_reset = 0;
        host_u.wait_n(3);
        host_u.send(8'h90);
        host_u.send(8'hc4);
        host_u.wait_n(600);
        host_u.send(8'hc4);
        host_u.send(8'h84);
        sel = 1;
        host_u.send(8'he4);
        host_u.get(b);
        check("status", b, 8'h84);
        check("early halt", 8'(halts), 8'h00);
        $display("end status");
        host_u.send(8'hd5);
        host_u.wait_n(16);
        check("ack", {7'h00, o_ack_enabled}, 8'h01);
        a = 16'($random(seed));
        host_u.send(8'hc2);
        host_u.send(a[15:8]);
        host_u.send(a[7:0]);
        check("match hi", o_breakpoint_match[15:8], a[15:8]);
        host_u.send(8'he2);
        host_u.get(b);
        check("match lo", o_breakpoint_match[7:0], a[7:0]);
        check("match read", b, a[15:8]);
        host_u.get(b);
        check("match read", b, a[7:0]);
        for (int k = 0; k < 4; k++) begin
            c = (k < 2) ? (8'hc0 | 8'(k)) : (8'he0 | 8'(k - 2));
            a = 16'($random(seed));
            d = 8'($random(seed));
            host_u.send(c);
            host_u.send(a[15:8]);
            host_u.send(a[7:0]);
            if (c[5] == 1'b0) host_u.send(d);
            host_u.wait_n(16);
            if (c[0]) host_u.get(b);
            if (c[0]) check("status", b, 8'h84);
            if (c[5]) q.push_back(a[7:0] ^ 8'h3c);
            if (c[5]) host_u.get(b);
            if (c[5]) check("read", b, a[7:0] ^ 8'h3c);
            else check("write", wd, d);
            check("addr", 8'(|(wa ^ a)), 8'h00);
        end
        $display("end memory");
        hold = 1;
        for (int k = 0; k < 16; k++) begin
            host_u.send(8'he8);
            host_u.get(b);
            host_u.get(d);
            q.push_back(a[7:0] ^ 8'h3c);
            check("reread status", b, 8'h84);
            check("reread", d, a[7:0] ^ 8'h3c);
        end
        hold = 0;
        host_u.wait_n(300);
        check("drained", 8'(q.size()), 8'h00);
        host_u.send(8'h08);
        host_u.wait_n(16);
        host_u.send(8'h90);
        host_u.wait_n(16);
        i_halted = 1;
        host_u.send(8'h08);
        host_u.wait_n(16);
        check("halt", 8'(halts), 8'h01);
        check("go", 8'(gos), 8'h01);
        host_u.probe(n);
        check("probe low", 8'(n), 8'h80);
        $display("end control");
        final_report();
    end
endmodule
